// [src/sbs_consts.svh]
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// clock and timing
`define SBS_CLK_HZ 100000000
`define SBS_MS_CYC (`SBS_CLK_HZ / 1000)
`define SBS_READY_DELAY_MS 16'd20
`define SBS_BRAKE_DELAY_RST_MS 16'd100

// output-function parameter code that selects the brake interlock
`define SBS_OUTFN_BRAKE 16'hdd1d

// controller register word offsets
`define SBS_REG_CTRL 3'h0
`define SBS_REG_STATUS 3'h1
`define SBS_REG_IRQ_STAT 3'h2
`define SBS_REG_IRQ_CLR 3'h3
`define SBS_REG_IRQ_EN 3'h4

// control register fields
`define SBS_CTRL_SERVO 0
`define SBS_CTRL_FWD 1
`define SBS_CTRL_REV 2
`define SBS_CTRL_PULSE 3
`define SBS_CTRL_RESET 4
`define SBS_CTRL_ESTOP 5
`define SBS_CTRL_W 6

// status register fields
`define SBS_ST_READY 0
`define SBS_ST_BRAKE_REL 1
`define SBS_ST_WARN 2
`define SBS_ST_ZERO_SPD 3
`define SBS_ST_SERVO 4
`define SBS_ST_PWR_CUT 5
`define SBS_ST_W 6

// interrupt fields
`define SBS_IRQ_WARN 0
`define SBS_IRQ_READY 1
`define SBS_IRQ_BRAKE 2
`define SBS_IRQ_W 3

// reset values
`define SBS_CTRL_RST 6'h00
`define SBS_IRQ_EN_RST 3'h0

`endif

// [src/sbs_pkg.sv]
package sbs_pkg;
   // sequencer states of the amplifier end
   typedef enum logic [2:0] {
      SBS_OFF,
      SBS_BASE_WAIT,
      SBS_RUN,
      SBS_BRAKE_HOLD,
      SBS_ESTOP
   } sbs_state_t;

   typedef logic [15:0] sbs_ms_t;
endpackage

// [src/sbs_link_if.sv]
`timescale 1ns/1ns
// link between external controller and amplifier sequencer
interface sbs_link_if;
   logic servo_on;
   logic reset_in;
   logic fwd_start;
   logic rev_start;
   logic pulse_in;
   logic estop_in;              // high = normal, low = emergency stop
   logic ready;
   logic brake_interlock_out;   // high = brake released
   logic zero_speed_out;
   logic estop_warning;

   modport dev (
      input servo_on, reset_in, fwd_start, rev_start, pulse_in, estop_in,
      output ready, brake_interlock_out, zero_speed_out, estop_warning
   );
   modport ctl (
      output servo_on, reset_in, fwd_start, rev_start, pulse_in, estop_in,
      input ready, brake_interlock_out, zero_speed_out, estop_warning
   );
endinterface

// [src/sbs_ms_timer.sv]
`timescale 1ns/1ns
// millisecond delay timer: start loads a length, done rises after it
module sbs_ms_timer #(
   parameter int CYC_PER_MS = 100000
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire sbs_pkg::sbs_ms_t len_ms_i,
   output logic done_o
);
   import sbs_pkg::*;

   localparam int DW = $clog2(CYC_PER_MS);
   localparam logic [DW-1:0] DIV_LAST = DW'(CYC_PER_MS - 1);

   logic [DW-1:0] div_r;
   sbs_ms_t cnt_r;
   logic busy_r;

   wire div_wrap = (div_r == DIV_LAST);
   wire cnt_zero = (cnt_r == 16'h0000);

   // =================================================
   // divider and ms countdown
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_r <= '0;
         cnt_r <= 16'h0000;
         busy_r <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         div_r <= '0;
         cnt_r <= len_ms_i;
         busy_r <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_r) begin
         if (cnt_zero) begin
            busy_r <= 1'b0;
            done_o <= 1'b1;
         end else if (div_wrap) begin
            div_r <= '0;
            cnt_r <= cnt_r - 16'h0001;
         end else begin
            div_r <= div_r + 1'b1;
         end
      end
   end
endmodule

// [src/sbs_amp_seq.sv]
`timescale 1ns/1ns
`include "sbs_consts.svh"

module sbs_amp_seq #(
   parameter int CYC_PER_MS = `SBS_MS_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   sbs_link_if.dev link,
   input wire logic [15:0] out_func_i,
   input wire sbs_pkg::sbs_ms_t brake_delay_ms_i,
   input wire logic motor_stopped_i,
   output logic base_on_o,
   output logic dyn_brake_o,
   output logic motor_drive_o,
   output sbs_pkg::sbs_state_t state_o
);
   import sbs_pkg::*;

   sbs_state_t state_r;
   sbs_state_t state_nxt;
   logic timer_start;
   sbs_ms_t timer_len;
   logic timer_done;
   logic ready_r;
   logic brake_rel_r;
   logic zero_spd_r;
   logic warn_r;
   logic [1:0] stop_sync_r;
   logic [15:0] out_func_r;
   sbs_ms_t delay_ms_r;

   // =================================================
   // input decode
   wire estop_act = !link.estop_in;
   wire run_cmd = link.fwd_start | link.rev_start | link.pulse_in;
   wire brake_fn = (out_func_r == `SBS_OUTFN_BRAKE);

   // =================================================
   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      timer_start = 1'b0;
      timer_len = `SBS_READY_DELAY_MS;
      case (state_r)
         SBS_OFF: begin
            if (link.servo_on && !link.reset_in) begin
               state_nxt = SBS_BASE_WAIT;
               timer_start = 1'b1;
            end
         end
         SBS_BASE_WAIT: begin
            if (!link.servo_on) begin
               state_nxt = SBS_OFF;
            end else if (timer_done) begin
               state_nxt = SBS_RUN;
            end
         end
         SBS_RUN: begin
            if (!link.servo_on) begin
               // brake drops now, lock kept for the delay
               state_nxt = SBS_BRAKE_HOLD;
               timer_start = 1'b1;
               timer_len = delay_ms_r;
            end
         end
         SBS_BRAKE_HOLD: begin
            if (timer_done) begin
               state_nxt = SBS_OFF;
            end
         end
         SBS_ESTOP: begin
            // warning clears; pending run commands restart the motor
            // once ready returns after the ready delay, so the controller must drop
            // them itself if it wants the motor to stay put
            if (!estop_act) begin
               if (link.servo_on && !link.reset_in) begin
                  state_nxt = SBS_BASE_WAIT;
                  timer_start = 1'b1;
               end else begin
                  state_nxt = SBS_OFF;
               end
            end
         end
         default: begin
            state_nxt = SBS_OFF;
         end
      endcase
      // estop outranks everything, reset input outranks servo states
      if (estop_act) begin
         state_nxt = SBS_ESTOP;
         timer_start = 1'b0;
      end else if (link.reset_in && state_r != SBS_ESTOP) begin
         state_nxt = SBS_OFF;
         timer_start = 1'b0;
      end
   end

   // =================================================
   // state register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= SBS_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // =================================================
   // standstill flag from the motor side, not our clock:
   // two flops before the zero-speed flop may read it
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stop_sync_r <= 2'b00;
      end else begin
         stop_sync_r <= {stop_sync_r[0], motor_stopped_i};
      end
   end

   // =================================================
   // settings captured each clock; the parameter store may be
   // rewritten at any time, decode only sees a settled copy
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_func_r <= 16'h0000;
         delay_ms_r <= `SBS_BRAKE_DELAY_RST_MS;
      end else begin
         out_func_r <= out_func_i;
         delay_ms_r <= brake_delay_ms_i;
      end
   end

   // =================================================
   // delay timer shared by ready delay and brake delay
   sbs_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_timer (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .start_i(timer_start),
      .len_ms_i(timer_len),
      .done_o(timer_done)
   );

   // =================================================
   // output decode from next state, so flops track the state
   wire base_nxt = (state_nxt == SBS_BASE_WAIT) ||
                   (state_nxt == SBS_RUN) ||
                   (state_nxt == SBS_BRAKE_HOLD);
   wire rel_nxt = (state_nxt == SBS_BASE_WAIT) ||
                  (state_nxt == SBS_RUN);
   wire drive_nxt = (state_nxt == SBS_RUN) && run_cmd;
   wire estop_nxt = (state_nxt == SBS_ESTOP);

   // =================================================
   // power stage flops; all low in reset so a glitching
   // reset can never leave the base circuit switched on
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         base_on_o <= 1'b0;
         dyn_brake_o <= 1'b0;
         motor_drive_o <= 1'b0;
      end else begin
         base_on_o <= base_nxt;
         dyn_brake_o <= estop_nxt;
         motor_drive_o <= drive_nxt;
      end
   end

   // =================================================
   // link output flops
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ready_r <= 1'b0;
         brake_rel_r <= 1'b0;
         zero_spd_r <= 1'b0;
         warn_r <= 1'b0;
      end else begin
         ready_r <= (state_nxt == SBS_RUN);
         // unselected function leaves the interlock engaged
         brake_rel_r <= brake_fn && rel_nxt;
         zero_spd_r <= !brake_fn && stop_sync_r[1];
         warn_r <= estop_nxt;
      end
   end

   // =================================================
   // link outputs
   assign link.ready = ready_r;
   assign link.brake_interlock_out = brake_rel_r;
   assign link.zero_speed_out = zero_spd_r;
   assign link.estop_warning = warn_r;
   assign state_o = state_r;
endmodule

// [src/sbs_ctl.sv]
`timescale 1ns/1ns
`include "sbs_consts.svh"

// external controller end: avalon registers in, link commands out
module sbs_ctl (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   sbs_link_if.ctl link,
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   input wire logic estop_btn_n_i,
   input wire logic motor_stopped_i,
   input wire logic pulse_train_i,
   output logic main_power_cut_o
);
   import sbs_pkg::*;

   logic [`SBS_CTRL_W-1:0] ctrl_r;
   logic [`SBS_IRQ_W-1:0] irq_stat_r;
   logic [`SBS_IRQ_W-1:0] irq_en_r;
   logic ack_r;
   logic [1:0] btn_sync_r;
   logic [1:0] stop_sync_r;
   logic [1:0] pulse_sync_r;
   logic servo_r;
   logic fwd_r;
   logic rev_r;
   logic pulse_r;
   logic rst_r;
   logic estop_n_r;
   logic [`SBS_IRQ_W-1:0] ev_prev_r;

   // =================================================
   // pin synchronisers, first stage read only by second
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         btn_sync_r <= 2'b00;
         stop_sync_r <= 2'b00;
         pulse_sync_r <= 2'b00;
      end else begin
         btn_sync_r <= {btn_sync_r[0], estop_btn_n_i};
         stop_sync_r <= {stop_sync_r[0], motor_stopped_i};
         pulse_sync_r <= {pulse_sync_r[0], pulse_train_i};
      end
   end

   // =================================================
   // bus decode; one wait cycle per access
   wire access = avs_read_i | avs_write_i;
   wire wr_take = avs_write_i & ack_r & avs_byteenable_i[0];
   wire wr_ctrl = wr_take && (avs_address_i == `SBS_REG_CTRL);
   wire wr_clr = wr_take && (avs_address_i == `SBS_REG_IRQ_CLR);
   wire wr_en = wr_take && (avs_address_i == `SBS_REG_IRQ_EN);
   assign avs_waitrequest_o = access & !ack_r;

   // =================================================
   // command shaping
   wire estop_act = !btn_sync_r[1] || ctrl_r[`SBS_CTRL_ESTOP];
   wire stopped = stop_sync_r[1];
   // servo-on falls only once the motor stands still
   wire servo_nxt = ctrl_r[`SBS_CTRL_SERVO] | (servo_r & !stopped);
   // run commands are withdrawn while estop stands
   wire fwd_nxt = ctrl_r[`SBS_CTRL_FWD] & !estop_act;
   wire rev_nxt = ctrl_r[`SBS_CTRL_REV] & !estop_act;
   // position pulses wait for the released brake
   wire pulse_nxt = ctrl_r[`SBS_CTRL_PULSE] & pulse_sync_r[1] &
                    link.brake_interlock_out & !estop_act;
   wire [`SBS_IRQ_W-1:0] ev_now = {link.brake_interlock_out, link.ready,
                                   link.estop_warning};
   wire [`SBS_IRQ_W-1:0] ev_rise = ev_now & ~ev_prev_r;
   wire [`SBS_ST_W-1:0] status = {main_power_cut_o, servo_r,
                                  link.zero_speed_out, link.estop_warning,
                                  link.brake_interlock_out, link.ready};

   // =================================================
   // register read mux, unmapped reads zero
   wire [31:0] rd_mux =
      (avs_address_i == `SBS_REG_CTRL) ? {26'h0, ctrl_r} :
      (avs_address_i == `SBS_REG_STATUS) ? {26'h0, status} :
      (avs_address_i == `SBS_REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
      (avs_address_i == `SBS_REG_IRQ_EN) ? {29'h0, irq_en_r} : 32'h0;

   // =================================================
   // bus handshake and read data
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else begin
         ack_r <= access & !ack_r;
         if (avs_read_i && !ack_r) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   // =================================================
   // software registers; a new event beats a same-cycle clear
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r <= `SBS_CTRL_RST;
         irq_en_r <= `SBS_IRQ_EN_RST;
         irq_stat_r <= '0;
         ev_prev_r <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= avs_writedata_i[`SBS_CTRL_W-1:0];
         end
         if (wr_en) begin
            irq_en_r <= avs_writedata_i[`SBS_IRQ_W-1:0];
         end
         irq_stat_r <= (irq_stat_r &
            ~(wr_clr ? avs_writedata_i[`SBS_IRQ_W-1:0] : '0)) | ev_rise;
         ev_prev_r <= ev_now;
      end
   end

   // =================================================
   // link command flops; estop kept as a level, never pulsed
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         servo_r <= 1'b0;
         fwd_r <= 1'b0;
         rev_r <= 1'b0;
         pulse_r <= 1'b0;
         rst_r <= 1'b0;
         estop_n_r <= 1'b0;
         main_power_cut_o <= 1'b1;
      end else begin
         servo_r <= servo_nxt;
         fwd_r <= fwd_nxt;
         rev_r <= rev_nxt;
         pulse_r <= pulse_nxt;
         rst_r <= ctrl_r[`SBS_CTRL_RESET];
         estop_n_r <= !estop_act;
         main_power_cut_o <= estop_act;
      end
   end

   assign link.servo_on = servo_r;
   assign link.fwd_start = fwd_r;
   assign link.rev_start = rev_r;
   assign link.pulse_in = pulse_r;
   assign link.reset_in = rst_r;
   assign link.estop_in = estop_n_r;
   assign irq_o = |(irq_stat_r & irq_en_r);
endmodule

// [test/sbs_link_monitor.sv]
`timescale 1ns/1ns
// ============================================================
// link checker between controller end and amplifier end
module sbs_link_monitor #(
   parameter int CYC_PER_MS = 100000
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic servo_on,
   input wire logic reset_in,
   input wire logic fwd_start,
   input wire logic rev_start,
   input wire logic pulse_in,
   input wire logic estop_in,
   input wire logic ready,
   input wire logic brake_interlock_out,
   input wire logic zero_speed_out,
   input wire logic estop_warning
);
   localparam int RDY = 20 * CYC_PER_MS;
   logic [15:0] brk_cnt_r;
   logic live_r;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i || !live_r);

   // the edge that lifts reset still finds the flops in reset,
   // so checking starts one edge later
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         live_r <= 1'b0;
      else
         live_r <= 1'b1;
   end

   // cycles since brake release; saturates so a long run never wraps
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         brk_cnt_r <= 16'h0;
      else if (!brake_interlock_out)
         brk_cnt_r <= 16'h0;
      else if (brk_cnt_r != 16'hffff)
         brk_cnt_r <= brk_cnt_r + 16'h1;
   end

   // ============================================================
   // link properties
   AST_ESTOP_WARN:
      assert property (!estop_in |=> estop_warning)
      else $error("warning missing during estop");
   AST_ESTOP_BRK:
      assert property (!estop_in |=> !brake_interlock_out)
      else $error("brake released during estop");
   AST_WARN_CLR:
      assert property ($rose(estop_in) |=> !estop_warning)
      else $error("warning kept after estop release");
   AST_RST_OFF:
      assert property (reset_in |=> !ready && !brake_interlock_out)
      else $error("drive active while reset input high");
   AST_RDY_WIN:
      assert property ($rose(ready) |->
         brk_cnt_r >= 16'(RDY - 4) && brk_cnt_r <= 16'(RDY + 6))
      else $error("ready delay out of window");
   AST_RDY_LATE:
      assert property (brk_cnt_r == 16'(RDY + 8) |-> ready)
      else $error("ready late after base on");
   AST_SOFF:
      assert property ($fell(servo_on) && ready |=>
         !brake_interlock_out ##[0:1] !ready)
      else $error("brake not engaged at servo off");
   AST_RUN_CUT:
      assert property (!estop_in && !$past(estop_in) |->
         !(fwd_start || rev_start || pulse_in))
      else $error("run command during estop");
   AST_PULSE_BRK:
      assert property (pulse_in |->
         $past(brake_interlock_out) || $past(brake_interlock_out, 2))
      else $error("pulses before brake release");
   AST_ZERO_SPD_BRK:
      assert property (!(zero_speed_out && brake_interlock_out))
      else $error("zero speed shown with brake function");

   // main scenarios reached
   cover property ($rose(ready));
   cover property ($fell(estop_in) && servo_on);
   cover property ($fell(servo_on) && ready);
endmodule

// [test/test_servo_brake_estop_sequencer.sv]
`timescale 1ns/1ns
`include "sbs_consts.svh"
// ============================================================
// bench top: controller end faces amplifier end
module test_servo_brake_estop_sequencer;
   import sbs_pkg::*;
   localparam int CYC = 10;
   localparam int RDY = 20 * CYC;
   localparam logic [31:0] C_SERVO = 32'h1 << `SBS_CTRL_SERVO;
   localparam logic [31:0] C_FWD = 32'h1 << `SBS_CTRL_FWD;
   localparam logic [31:0] C_REV = 32'h1 << `SBS_CTRL_REV;
   localparam logic [31:0] C_PLS = 32'h1 << `SBS_CTRL_PULSE;
   localparam logic [31:0] C_RST = 32'h1 << `SBS_CTRL_RESET;
   localparam logic [31:0] ST_RUN = (32'h1 << `SBS_ST_READY) |
      (32'h1 << `SBS_ST_BRAKE_REL) | (32'h1 << `SBS_ST_SERVO);
   logic sys_clk_i;
   logic rstn_i;
   logic [2:0] avs_adr;
   logic avs_rd;
   logic avs_wr;
   logic [31:0] avs_wdata;
   logic [3:0] avs_be;
   logic [31:0] avs_rdata;
   logic avs_wait;
   logic irq;
   logic btn_n;
   logic stopped;
   logic pulse_tr;
   logic pwr_cut;
   logic [15:0] out_func;
   sbs_ms_t delay_ms;
   logic base_on;
   logic dyn_brake;
   logic drive;
   sbs_state_t state;
   logic [31:0] rd;
   int n;
   int bad_count;
   int check_count;

   sbs_link_if u_sbs_link_if();
   wire rdy = u_sbs_link_if.ready;
   wire brk = u_sbs_link_if.brake_interlock_out;
   wire warn = u_sbs_link_if.estop_warning;

   sbs_amp_seq #(.CYC_PER_MS(CYC)) u_sbs_amp_seq (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .link(u_sbs_link_if.dev),
      .out_func_i(out_func),
      .brake_delay_ms_i(delay_ms),
      .motor_stopped_i(stopped),
      .base_on_o(base_on),
      .dyn_brake_o(dyn_brake),
      .motor_drive_o(drive),
      .state_o(state)
   );
   sbs_ctl u_sbs_ctl (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .link(u_sbs_link_if.ctl),
      .avs_address_i(avs_adr),
      .avs_read_i(avs_rd),
      .avs_write_i(avs_wr),
      .avs_writedata_i(avs_wdata),
      .avs_byteenable_i(avs_be),
      .avs_readdata_o(avs_rdata),
      .avs_waitrequest_o(avs_wait),
      .irq_o(irq),
      .estop_btn_n_i(btn_n),
      .motor_stopped_i(stopped),
      .pulse_train_i(pulse_tr),
      .main_power_cut_o(pwr_cut)
   );
   sbs_link_monitor #(.CYC_PER_MS(CYC)) u_sbs_link_monitor (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .servo_on(u_sbs_link_if.servo_on),
      .reset_in(u_sbs_link_if.reset_in),
      .fwd_start(u_sbs_link_if.fwd_start),
      .rev_start(u_sbs_link_if.rev_start),
      .pulse_in(u_sbs_link_if.pulse_in),
      .estop_in(u_sbs_link_if.estop_in),
      .ready(u_sbs_link_if.ready),
      .brake_interlock_out(u_sbs_link_if.brake_interlock_out),
      .zero_speed_out(u_sbs_link_if.zero_speed_out),
      .estop_warning(u_sbs_link_if.estop_warning)
   );

   // 100 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // ============================================================
   // shared tasks
   task chkb(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one access; held until waitrequest low, then an idle edge
   task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      avs_adr <= a;
      avs_wdata <= d;
      avs_wr <= wr;
      avs_rd <= !wr;
      @(posedge sys_clk_i);
      while (avs_wait !== 1'b0) @(posedge sys_clk_i);
      rd = avs_rdata;
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return rdy;
         1: return brk;
         2: return warn;
         default: return base_on;
      endcase
   endfunction
   // edges until a level is reached, bounded so a dead design fails
   task wt(input int s, input logic v);
      n = 0;
      while (pick(s) !== v && n < 600) begin
         @(posedge sys_clk_i);
         n++;
      end
      chkb("wait_level", v, pick(s));
   endtask

   // ============================================================
   // scenarios
   task t_regs;
      bus(1'b0, `SBS_REG_CTRL, 32'h0);
      chkw("ctrl_rst", 32'(`SBS_CTRL_RST), rd);
      bus(1'b0, `SBS_REG_IRQ_EN, 32'h0);
      chkw("irq_en_rst", 32'(`SBS_IRQ_EN_RST), rd);
      bus(1'b1, `SBS_REG_IRQ_STAT, 32'h0);
      bus(1'b0, `SBS_REG_IRQ_STAT, 32'h0);
      chkw("irq_stat", 32'h1 << `SBS_IRQ_WARN, rd);
      chkb("irq_masked", 1'b0, irq);
      bus(1'b1, `SBS_REG_IRQ_EN, 32'h7);
      chkb("irq_on", 1'b1, irq);
      bus(1'b1, `SBS_REG_IRQ_CLR, 32'h7);
      chkb("irq_clr", 1'b0, irq);
      bus(1'b0, `SBS_REG_IRQ_CLR, 32'h0);
      chkw("clr_wo", 32'h0, rd);
      bus(1'b1, 3'h7, 32'hff);
      bus(1'b0, 3'h7, 32'h0);
      chkw("unmapped", 32'h0, rd);
      // byte lane 0 off: the write must leave the enables alone
      avs_be <= 4'he;
      bus(1'b1, `SBS_REG_IRQ_EN, 32'h0);
      avs_be <= 4'hf;
      bus(1'b0, `SBS_REG_IRQ_EN, 32'h0);
      chkw("irq_en_rw", 32'h7, rd);
   endtask
   task t_outfn;
      stopped <= 1'b1;
      out_func <= 16'h0000;
      repeat (6) @(posedge sys_clk_i);
      chkb("zero_spd_shown", 1'b1, u_sbs_link_if.zero_speed_out);
      out_func <= `SBS_OUTFN_BRAKE;
      repeat (6) @(posedge sys_clk_i);
      chkb("zero_spd_hidden", 1'b0, u_sbs_link_if.zero_speed_out);
      stopped <= 1'b0;
   endtask
   task t_son(input logic [31:0] c);
      // stale events cleared so the irq check below means something
      bus(1'b1, `SBS_REG_IRQ_CLR, 32'h7);
      chkb("irq_idle", 1'b0, irq);
      bus(1'b1, `SBS_REG_CTRL, c);
      wt(1, 1'b1);
      chkb("brk_fast", 1'b1, n <= 4);
      chkb("base_on", 1'b1, base_on);
      wt(0, 1'b1);
      chkb("rdy_win", 1'b1, n >= RDY - 4 && n <= RDY + 6);
      repeat (2) @(posedge sys_clk_i);
      chkb("drive", 1'b1, drive);
      chkw("state_run", 32'(SBS_RUN), 32'(state));
      bus(1'b0, `SBS_REG_STATUS, 32'h0);
      chkw("status", ST_RUN, rd & ~(32'h1 << `SBS_ST_PWR_CUT));
      chkb("irq_event", 1'b1, irq);
      bus(1'b1, `SBS_REG_IRQ_CLR, 32'h7);
   endtask
   task t_estop;
      btn_n <= 1'b0;
      wt(2, 1'b1);
      chkb("warn_fast", 1'b1, n <= 6);
      chkb("dyn_brake", 1'b1, dyn_brake);
      chkw("state_estop", 32'(SBS_ESTOP), 32'(state));
      chkb("brk_eng", 1'b0, brk);
      chkb("pwr_cut", 1'b1, pwr_cut);
      chkb("fwd_cut", 1'b0, u_sbs_link_if.fwd_start);
      bus(1'b0, `SBS_REG_STATUS, 32'h0);
      chkb("st_warn", 1'b1, rd[`SBS_ST_WARN]);
      chkb("irq_warn", 1'b1, irq);
      btn_n <= 1'b1;
      wt(2, 1'b0);
      chkb("warn_clr", 1'b1, n <= 6);
      chkb("pwr_back", 1'b0, pwr_cut);
      wt(0, 1'b1);
      repeat (2) @(posedge sys_clk_i);
      chkb("drive_resume", 1'b1, drive);
   endtask
   // servo off; controller holds servo on until the motor stops
   task t_soff(input int ms);
      delay_ms <= 16'(ms);
      stopped <= 1'b0;
      bus(1'b1, `SBS_REG_CTRL, 32'h0);
      repeat (8) @(posedge sys_clk_i);
      chkb("servo_held", 1'b1, u_sbs_link_if.servo_on);
      stopped <= 1'b1;
      wt(1, 1'b0);
      if (ms > 0)
         chkb("base_first", 1'b1, base_on);
      wt(3, 1'b0);
      chkb("delay_win", 1'b1, n + 1 >= ms * CYC && n <= ms * CYC + 5);
      chkb("rdy_off", 1'b0, rdy);
   endtask
   task t_rst;
      bus(1'b1, `SBS_REG_CTRL, C_SERVO | C_FWD | C_RST);
      repeat (RDY + 20) @(posedge sys_clk_i);
      chkb("rst_base", 1'b0, base_on);
      chkb("rst_rdy", 1'b0, rdy);
      // software stop bit takes the same path as the button
      bus(1'b1, `SBS_REG_CTRL, 32'h1 << `SBS_CTRL_ESTOP);
      wt(2, 1'b1);
      chkb("sw_estop", 1'b1, n <= 4);
      chkb("sw_pwr_cut", 1'b1, pwr_cut);
      bus(1'b1, `SBS_REG_CTRL, 32'h0);
      wt(2, 1'b0);
      chkb("sw_estop_clr", 1'b1, n <= 4);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog: the run needs about 1000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      end_sim;
   end

   // main sequence
   initial begin
      rstn_i = 1'b0;
      avs_adr = 3'h0;
      avs_rd = 1'b0;
      avs_wr = 1'b0;
      avs_wdata = 32'h0;
      avs_be = 4'hf;
      btn_n = 1'b1;
      stopped = 1'b0;
      pulse_tr = 1'b1;
      out_func = `SBS_OUTFN_BRAKE;
      delay_ms = 16'h0;
      repeat (6) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      t_regs;
      t_outfn;
      t_son(C_SERVO | C_FWD | C_PLS);
      t_estop;
      t_soff(3);
      t_son(C_SERVO | C_REV);
      t_soff(0);
      t_rst;
      end_sim;
   end
endmodule
